//--- core/bcc_pkg.sv
// shared constants and types for the status bus command controller
package bcc_pkg;

	// ==========================================================
	// status codes (bit2, bit1, bit0)
	localparam logic [2:0] ST_IRQ_ACK  = 3'h0;
	localparam logic [2:0] ST_IO_READ  = 3'h1;
	localparam logic [2:0] ST_IO_WRITE = 3'h2;
	localparam logic [2:0] ST_HALT     = 3'h3;
	localparam logic [2:0] ST_CODE_RD  = 3'h4;
	localparam logic [2:0] ST_MEM_READ = 3'h5;
	localparam logic [2:0] ST_MEM_WR   = 3'h6;
	localparam logic [2:0] ST_PASSIVE  = 3'h7;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int GRANT_WAIT_NS = 105;
	// least time: round up to whole cycles
	localparam int GRANT_WAIT_CYC =
		(GRANT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GRANT_CNT_W = 3;

	// ==========================================================
	// reset values
	localparam logic RST_IO_MODE    = 1'b0;
	localparam logic RST_ACK_SECOND = 1'b0;

	// ==========================================================
	// types
	typedef struct packed {
		logic irq_ack;
		logic io_read;
		logic io_write;
		logic halt;
		logic mem_read;
		logic mem_write;
		logic passive;
	} bcc_cycle_type;

	typedef enum logic [1:0] {
		BCC_IDLE,
		BCC_STROBE,
		BCC_EARLY,
		BCC_LATE
	} bcc_state_type;

endpackage

//--- core/bcc_status_decode.sv
// status code to bus cycle class decoder
`timescale 1ns/1ps
`default_nettype none
module bcc_status_decode (
	input  wire logic [2:0]             status,
	output bcc_pkg::bcc_cycle_type      cycle
);

	// ==========================================================
	// decode
	assign cycle.irq_ack   = (status == bcc_pkg::ST_IRQ_ACK);
	assign cycle.io_read   = (status == bcc_pkg::ST_IO_READ);
	assign cycle.io_write  = (status == bcc_pkg::ST_IO_WRITE);
	assign cycle.halt      = (status == bcc_pkg::ST_HALT);
	// code fetch and data read both raise the memory read strobe
	assign cycle.mem_read  = (status == bcc_pkg::ST_CODE_RD) ||
		(status == bcc_pkg::ST_MEM_READ);
	assign cycle.mem_write = (status == bcc_pkg::ST_MEM_WR);
	assign cycle.passive   = (status == bcc_pkg::ST_PASSIVE);

endmodule
`default_nettype wire

//--- core/bcc_grant_delay.sv
// qualifies the bus grant after it has been held low long enough
`timescale 1ns/1ps
`default_nettype none
module bcc_grant_delay #(
	parameter int WAIT_CYC = bcc_pkg::GRANT_WAIT_CYC
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic bus_grant_enable_n,
	output logic      granted
);

	localparam logic [bcc_pkg::GRANT_CNT_W-1:0] CNT_TOP =
		bcc_pkg::GRANT_CNT_W'(WAIT_CYC);

	logic [bcc_pkg::GRANT_CNT_W-1:0] cnt_q;
	logic [bcc_pkg::GRANT_CNT_W-1:0] cnt_d;
	logic                            granted_q;

	// ==========================================================
	// low-time counter; any high level restarts it at once
	assign cnt_d = bus_grant_enable_n ? '0 :
		(cnt_q == CNT_TOP) ? cnt_q : cnt_q + 1'b1;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_q     <= '0;
			granted_q <= 1'b0;
		end else begin
			cnt_q     <= cnt_d;
			granted_q <= (cnt_d == CNT_TOP);
		end
	end

	assign granted = granted_q;

endmodule
`default_nettype wire

//--- core/bcc_controller.sv
// status driven bus command controller, top level
// Notes on behaviour
// - status code selects command per cycle type
// - strap high means i/o bus mode
// - system mode commands wait 105 ns grant
// - grant inactive floats memory command outputs, and i/o ones in system bus mode
// - i/o bus mode: i/o commands always enabled
// - gate low holds commands and controls inactive
// - direction high on writes, low reads
// - data enable per mode, peripheral enable
// - cascade enable on first interrupt acknowledge, system bus mode only
// - address strobe every cycle, halt included
// - strobe starts when status leaves passive
// - status copy captured on the clock edge that raises the strobe
// - early memory write precedes late write
// - early i/o write precedes late write
// - interrupt acknowledge acts as i/o read
// - everything clocked on one clock
`timescale 1ns/1ps
`default_nettype none
module bcc_controller #(
	parameter int GRANT_CYC = bcc_pkg::GRANT_WAIT_CYC
) (
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic status_code_bit0,
	input  wire logic status_code_bit1,
	input  wire logic status_code_bit2,
	input  wire logic io_bus_mode_select,
	input  wire logic bus_grant_enable_n,
	input  wire logic command_gate,
	output logic      address_strobe,
	output logic      mem_read_cmd,
	output logic      mem_write_cmd,
	output logic      early_mem_write_cmd,
	output logic      io_read_cmd,
	output logic      io_write_cmd,
	output logic      early_io_write_cmd,
	output logic      irq_ack_cmd,
	output logic      mem_cmd_oe,
	output logic      io_cmd_oe,
	output logic      xfer_direction,
	output logic      data_xcvr_enable,
	output logic      cascade_enable,
	output logic      periph_data_enable
);

	// ==========================================================
	// declarations
	logic [2:0]             status;
	bcc_pkg::bcc_cycle_type dec_cyc;
	bcc_pkg::bcc_cycle_type cyc_q;
	bcc_pkg::bcc_cycle_type cyc_sel;
	bcc_pkg::bcc_state_type state_q;
	bcc_pkg::bcc_state_type state_d;
	logic                   iomode_q;
	logic                   ack_second_q;
	logic                   granted;

	logic strobe_ph;
	logic active_ph;
	logic late_ph;
	logic start_cyc;
	logic io_class;
	logic mem_en;
	logic io_en;

	logic ale_d;
	logic mrd_d;
	logic mwr_d;
	logic emw_d;
	logic ior_d;
	logic iow_d;
	logic eiow_d;
	logic ack_d;
	logic moe_d;
	logic ioe_d;
	logic dir_d;
	logic xen_d;
	logic casc_d;
	logic pxen_d;

	logic ale_q;
	logic mrd_q;
	logic mwr_q;
	logic emw_q;
	logic ior_q;
	logic iow_q;
	logic eiow_q;
	logic ack_q;
	logic moe_q;
	logic ioe_q;
	logic dir_q;
	logic xen_q;
	logic casc_q;
	logic pxen_q;

	// ==========================================================
	// status decode and grant qualification
	assign status = {status_code_bit2, status_code_bit1,
		status_code_bit0};

	bcc_status_decode u_decode (
		.status (status),
		.cycle  (dec_cyc)
	);

	// the grant path gates memory commands in both modes, i/o only in system bus mode;
	// the arbiter is trusted to grant only a free bus
	bcc_grant_delay #(
		.WAIT_CYC (GRANT_CYC)
	) u_grant (
		.core_clk           (core_clk),
		.rst                (rst),
		.bus_grant_enable_n (bus_grant_enable_n),
		.granted            (granted)
	);

	// ==========================================================
	// machine cycle sequencing
	// a new cycle starts only from idle, so the status must
	// pass through passive between cycles
	always_comb begin
		state_d = state_q;
		case (state_q)
			bcc_pkg::BCC_IDLE: begin
				if (!dec_cyc.passive)
					state_d = bcc_pkg::BCC_STROBE;
			end
			bcc_pkg::BCC_STROBE: begin
				if (dec_cyc.passive)
					state_d = bcc_pkg::BCC_IDLE;
				else
					state_d = bcc_pkg::BCC_EARLY;
			end
			bcc_pkg::BCC_EARLY: begin
				if (dec_cyc.passive)
					state_d = bcc_pkg::BCC_IDLE;
				else
					state_d = bcc_pkg::BCC_LATE;
			end
			bcc_pkg::BCC_LATE: begin
				if (dec_cyc.passive)
					state_d = bcc_pkg::BCC_IDLE;
			end
			default: state_d = bcc_pkg::BCC_IDLE;
		endcase
	end

	assign start_cyc = (state_q == bcc_pkg::BCC_IDLE) &&
		(state_d == bcc_pkg::BCC_STROBE);
	// the strobe latches the status; later phases use the copy
	assign cyc_sel   = start_cyc ? dec_cyc : cyc_q;
	assign strobe_ph = (state_d == bcc_pkg::BCC_STROBE);
	assign active_ph = (state_d == bcc_pkg::BCC_EARLY) ||
		(state_d == bcc_pkg::BCC_LATE);
	assign late_ph   = (state_d == bcc_pkg::BCC_LATE);
	assign io_class  = cyc_sel.io_read || cyc_sel.io_write ||
		cyc_sel.irq_ack;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_q <= bcc_pkg::BCC_IDLE;
			cyc_q   <= '0;
			iomode_q     <= bcc_pkg::RST_IO_MODE;
			ack_second_q <= bcc_pkg::RST_ACK_SECOND;
		end else begin
			state_q  <= state_d;
			iomode_q <= io_bus_mode_select;
			if (start_cyc)
				cyc_q <= dec_cyc;
			// acknowledges come in pairs; any other transfer
			// resynchronises the pair, halt leaves it alone
			if (start_cyc && dec_cyc.irq_ack)
				ack_second_q <= !ack_second_q;
			else if (start_cyc && !dec_cyc.halt)
				ack_second_q <= 1'b0;
		end
	end

	// ==========================================================
	// enables: memory always waits for the grant; i/o waits
	// only in system bus mode
	assign mem_en = command_gate && granted;
	assign io_en  = command_gate && (iomode_q || granted);

	// ==========================================================
	// next output values
	assign ale_d  = strobe_ph;
	assign mrd_d  = active_ph && cyc_sel.mem_read && mem_en;
	assign emw_d  = active_ph && cyc_sel.mem_write && mem_en;
	assign mwr_d  = late_ph && cyc_sel.mem_write && mem_en;
	assign ior_d  = active_ph && cyc_sel.io_read && io_en;
	assign eiow_d = active_ph && cyc_sel.io_write && io_en;
	assign iow_d  = late_ph && cyc_sel.io_write && io_en;
	// acknowledge strobe is timed exactly like the i/o read
	assign ack_d  = active_ph && cyc_sel.irq_ack && io_en;
	assign moe_d  = granted;
	assign ioe_d  = iomode_q || granted;
	assign dir_d  = command_gate && active_ph &&
		(cyc_sel.mem_write || cyc_sel.io_write);
	// in i/o mode the i/o class uses the peripheral enable
	assign xen_d  = active_ph && !cyc_sel.halt && command_gate &&
		granted && !(iomode_q && io_class);
	assign pxen_d = active_ph && iomode_q && io_class && command_gate;
	// cascade address goes out with the strobe of the first
	// acknowledge only, and only in system bus mode
	assign casc_d = strobe_ph && !iomode_q && cyc_sel.irq_ack &&
		!ack_second_q && command_gate;

	// ==========================================================
	// output registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ale_q  <= 1'b0;
			mrd_q  <= 1'b0;
			mwr_q  <= 1'b0;
			emw_q  <= 1'b0;
			ior_q  <= 1'b0;
			iow_q  <= 1'b0;
			eiow_q <= 1'b0;
			ack_q  <= 1'b0;
			moe_q  <= 1'b0;
			ioe_q  <= 1'b0;
			dir_q  <= 1'b0;
			xen_q  <= 1'b0;
			casc_q <= 1'b0;
			pxen_q <= 1'b0;
		end else begin
			ale_q  <= ale_d;
			mrd_q  <= mrd_d;
			mwr_q  <= mwr_d;
			emw_q  <= emw_d;
			ior_q  <= ior_d;
			iow_q  <= iow_d;
			eiow_q <= eiow_d;
			ack_q  <= ack_d;
			moe_q  <= moe_d;
			ioe_q  <= ioe_d;
			dir_q  <= dir_d;
			xen_q  <= xen_d;
			casc_q <= casc_d;
			pxen_q <= pxen_d;
		end
	end

	assign address_strobe      = ale_q;
	assign mem_read_cmd        = mrd_q;
	assign mem_write_cmd       = mwr_q;
	assign early_mem_write_cmd = emw_q;
	assign io_read_cmd         = ior_q;
	assign io_write_cmd        = iow_q;
	assign early_io_write_cmd  = eiow_q;
	assign irq_ack_cmd         = ack_q;
	assign mem_cmd_oe          = moe_q;
	assign io_cmd_oe           = ioe_q;
	assign xfer_direction      = dir_q;
	assign data_xcvr_enable    = xen_q;
	assign cascade_enable      = casc_q;
	assign periph_data_enable  = pxen_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_strobe_single: assert property (
		ale_q |=> !ale_q)
		else $error("address strobe longer than one cycle");

	chk_strobe_start: assert property (
		(state_q == bcc_pkg::BCC_IDLE) && !dec_cyc.passive |=> ale_q)
		else $error("no strobe after status left passive");

	// the command register lags the qualified grant by one edge
	chk_grant_wait: assert property (
		mrd_q |-> $past(!bus_grant_enable_n, 2) &&
		$past(!bus_grant_enable_n, 3) && $past(!bus_grant_enable_n, 4))
		else $error("memory read before grant wait");

	// a released grant reaches the drive enables two edges later
	chk_float_cmds: assert property (
		bus_grant_enable_n && !iomode_q && !io_bus_mode_select
		|-> ##2 !moe_q && !ioe_q)
		else $error("commands driven without grant");

	chk_mem_driven: assert property (
		mrd_q || emw_q || mwr_q |-> moe_q)
		else $error("memory command while drivers floated");

	chk_iomode_io_on: assert property (
		iomode_q |=> ioe_q)
		else $error("i/o commands floated in i/o bus mode");

	chk_gate_off: assert property (
		!command_gate |=> !mrd_q && !mwr_q && !emw_q && !ior_q && !iow_q &&
		!eiow_q && !ack_q && !casc_q && !xen_q && !pxen_q && !dir_q)
		else $error("output active with gate low");

	chk_read_dir: assert property (
		mrd_q || ior_q || ack_q |-> !dir_q)
		else $error("direction high during read");

	chk_halt_quiet: assert property (
		(state_q != bcc_pkg::BCC_IDLE) && cyc_q.halt |-> !mrd_q && !emw_q &&
		!mwr_q && !ior_q && !eiow_q && !iow_q && !ack_q && !xen_q)
		else $error("command issued in halt cycle");

	chk_iomode_enable: assert property (
		iomode_q && $past(iomode_q) && (ior_q || eiow_q || ack_q)
		|-> pxen_q && !xen_q)
		else $error("wrong transceiver enable in i/o bus mode");

	chk_write_dir: assert property (
		emw_q || eiow_q |-> dir_q)
		else $error("direction low during write");

	chk_late_write: assert property (
		$rose(mwr_q) || $rose(iow_q) |-> $past(emw_q || eiow_q))
		else $error("late write without early write before");

	chk_cascade_strobe: assert property (
		casc_q |-> ale_q && !iomode_q)
		else $error("cascade enable outside strobe");

	chk_passive_end: assert property (
		(state_q == bcc_pkg::BCC_LATE) && dec_cyc.passive
		|=> !mrd_q && !mwr_q && !ior_q && !iow_q && !ack_q &&
		!xen_q && !pxen_q)
		else $error("command left on after passive");

	cov_mem_read: cover property (
		ale_q ##1 mrd_q [*2]);
	cov_io_write_iomode: cover property (
		iomode_q && eiow_q ##1 iow_q && pxen_q);
	cov_cascade: cover property (
		casc_q ##1 ack_q);
	cov_ack_iomode: cover property (
		iomode_q && ack_q && pxen_q);
	cov_halt_strobe: cover property (
		ale_q && cyc_q.halt);

endmodule
`default_nettype wire

//--- bench/bcc_far_model.sv
// far side model: processor status lines and bus arbiter
`timescale 1ns/1ps
`default_nettype none
module bcc_far_model (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       cyc_start,
	input  wire logic [2:0] cyc_code,
	input  wire logic [3:0] cyc_len,
	input  wire logic       bus_free,
	input  wire logic [3:0] grant_lag,
	output logic            status_code_bit0,
	output logic            status_code_bit1,
	output logic            status_code_bit2,
	output logic            bus_grant_enable_n
);
	logic [2:0] status_q;
	logic [3:0] hold_q;
	logic [3:0] lag_q;

	assign {status_code_bit2, status_code_bit1, status_code_bit0} = status_q;

	// =========================================================
	// status: moves after the falling edge so it settles before sampling
	always_ff @(negedge core_clk) begin
		if (rst) begin
			status_q <= bcc_pkg::ST_PASSIVE;
			hold_q   <= 4'h0;
		end else if (cyc_start && hold_q == 4'h0) begin
			status_q <= cyc_code;
			hold_q   <= cyc_len;
		end else if (hold_q > 4'h1) begin
			hold_q <= hold_q - 4'h1;
		end else begin
			status_q <= bcc_pkg::ST_PASSIVE;
			hold_q   <= 4'h0;
		end
	end

	// =========================================================
	// arbiter: a lag models a slow one; the grant drops as soon as the bus is taken
	always_ff @(negedge core_clk) begin
		if (rst || !bus_free) begin
			bus_grant_enable_n <= 1'b1;
			lag_q              <= 4'h0;
		end else if (lag_q >= grant_lag) begin
			bus_grant_enable_n <= 1'b0;
		end else begin
			lag_q <= lag_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

//--- bench/bcc_controller_tb.sv
// self-checking testbench for the status bus command controller
`timescale 1ns/1ps
`default_nettype none
module bcc_controller_tb;
	localparam int GRANT_CYC = 3;
	localparam int LIMIT     = 2000;
	localparam logic [2:0]  SYS_CODE [10] = '{3'h5, 3'h4, 3'h6, 3'h1, 3'h2, 3'h3, 3'h0, 3'h0, 3'h1, 3'h0};
	localparam logic [11:0] SYS_EXP  [10] = '{12'h203, 12'h203, 12'h30d, 12'h211, 12'h361,
		12'h001, 12'h681, 12'h281, 12'h211, 12'h681};
	logic        core_clk, rst, io_bus_mode_select, command_gate, cyc_start, bus_free;
	logic [2:0]  cyc_code;
	logic [3:0]  cyc_len, grant_lag;
	wire logic   status_code_bit0, status_code_bit1, status_code_bit2, bus_grant_enable_n;
	logic        address_strobe, mem_read_cmd, mem_write_cmd, early_mem_write_cmd, io_read_cmd;
	logic        io_write_cmd, early_io_write_cmd, irq_ack_cmd, mem_cmd_oe, io_cmd_oe;
	logic        xfer_direction, data_xcvr_enable, cascade_enable, periph_data_enable;
	logic [11:0] outs;
	logic [7:0]  first_hi [12];
	logic [7:0]  tick;
	int          errors, check_count, cycles;

	assign outs = {periph_data_enable, cascade_enable, data_xcvr_enable, xfer_direction, irq_ack_cmd,
		early_io_write_cmd, io_write_cmd, io_read_cmd, early_mem_write_cmd, mem_write_cmd, mem_read_cmd,
		address_strobe};

	bcc_controller #(.GRANT_CYC(GRANT_CYC)) DUT (.core_clk(core_clk), .rst(rst),
		.status_code_bit0(status_code_bit0), .status_code_bit1(status_code_bit1),
		.status_code_bit2(status_code_bit2), .io_bus_mode_select(io_bus_mode_select),
		.bus_grant_enable_n(bus_grant_enable_n), .command_gate(command_gate),
		.address_strobe(address_strobe), .mem_read_cmd(mem_read_cmd), .mem_write_cmd(mem_write_cmd),
		.early_mem_write_cmd(early_mem_write_cmd), .io_read_cmd(io_read_cmd), .io_write_cmd(io_write_cmd),
		.early_io_write_cmd(early_io_write_cmd), .irq_ack_cmd(irq_ack_cmd), .mem_cmd_oe(mem_cmd_oe),
		.io_cmd_oe(io_cmd_oe), .xfer_direction(xfer_direction), .data_xcvr_enable(data_xcvr_enable),
		.cascade_enable(cascade_enable), .periph_data_enable(periph_data_enable));

	bcc_far_model far (.core_clk(core_clk), .rst(rst), .cyc_start(cyc_start), .cyc_code(cyc_code),
		.cyc_len(cyc_len), .bus_free(bus_free), .grant_lag(grant_lag), .status_code_bit0(status_code_bit0),
		.status_code_bit1(status_code_bit1), .status_code_bit2(status_code_bit2),
		.bus_grant_enable_n(bus_grant_enable_n));

	// =========================================================
	// clock, cycle limit and first-rise monitor
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			finish_test();
		end
	end

	// looks just after the edge so the registered outputs have landed
	always @(posedge core_clk) begin
		#1;
		tick++;
		for (int i = 0; i < 12; i++) begin
			if (outs[i] === 1'b1 && first_hi[i] == 8'hff) begin
				first_hi[i] = tick;
			end
		end
	end

	// =========================================================
	// shared tasks
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (errors == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// one whole bus cycle; when timed, offsets of each expected rise are judged against the strobe
	task automatic run_cycle(input logic [2:0] code, input logic [11:0] exp, input logic [11:0] care,
		input bit timed);
		logic [11:0] seen;
		logic [7:0]  lat;
		@(negedge core_clk);
		first_hi = '{default: 8'hff};
		tick = 8'h0;
		cyc_code <= code;
		cyc_start <= 1'b1;
		@(negedge core_clk);
		cyc_start <= 1'b0;
		repeat (9) @(negedge core_clk);
		for (int i = 0; i < 12; i++) begin
			seen[i] = (first_hi[i] != 8'hff);
		end
		check(seen & care, exp & care);
		for (int i = 1; i < 12; i++) begin
			lat = (i == 10) ? 8'h0 : ((i == 2 || i == 5) ? 8'h2 : 8'h1);
			if (timed && exp[i]) begin
				check(12'(first_hi[i] - first_hi[0]), 12'(lat));
			end
		end
		check(outs, 12'h000);
	endtask

	// =========================================================
	// scenarios
	task automatic test_grant();
		int n;
		n = 0;
		@(negedge core_clk);
		grant_lag <= 4'h2;
		bus_free <= 1'b1;
		while (mem_cmd_oe !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		check(12'(n), 12'(GRANT_CYC + 4));
		check(12'(io_cmd_oe), 12'h001);
		bus_free <= 1'b0;
		repeat (4) @(negedge core_clk);
		check(12'({mem_cmd_oe, io_cmd_oe}), 12'h000);
		grant_lag <= 4'h0;
		bus_free <= 1'b1;
		repeat (8) @(negedge core_clk);
	endtask

	task automatic test_system();
		for (int i = 0; i < 10; i++) begin
			run_cycle(SYS_CODE[i], SYS_EXP[i], 12'hfff, 1'b1);
		end
	endtask

	task automatic test_gate_and_grant();
		command_gate <= 1'b0;
		run_cycle(3'h6, 12'h001, 12'hfff, 1'b0);
		run_cycle(3'h0, 12'h001, 12'hfff, 1'b0);
		command_gate <= 1'b1;
		bus_free <= 1'b0;
		repeat (5) @(negedge core_clk);
		run_cycle(3'h1, 12'h001, 12'hfff, 1'b0);
		run_cycle(3'h5, 12'h001, 12'hfff, 1'b0);
	endtask

	task automatic test_io_mode();
		io_bus_mode_select <= 1'b1;
		repeat (3) @(negedge core_clk);
		check(12'({mem_cmd_oe, io_cmd_oe}), 12'h001);
		run_cycle(3'h2, 12'h961, 12'hfff, 1'b1);
		run_cycle(3'h1, 12'h811, 12'hfff, 1'b1);
		run_cycle(3'h0, 12'h881, 12'hfff, 1'b1);
		run_cycle(3'h5, 12'h001, 12'hfff, 1'b0);
		bus_free <= 1'b1;
		repeat (8) @(negedge core_clk);
		run_cycle(3'h5, 12'h203, 12'hfff, 1'b1);
	endtask

	initial begin
		rst = 1'b1;
		io_bus_mode_select = 1'b0;
		command_gate = 1'b1;
		cyc_start = 1'b0;
		cyc_code = 3'h7;
		cyc_len = 4'h5;
		bus_free = 1'b0;
		grant_lag = 4'h0;
		errors = 0;
		check_count = 0;
		cycles = 0;
		tick = 8'h0;
		repeat (2) @(negedge core_clk);
		rst <= 1'b0;
		test_grant();
		test_system();
		test_gate_and_grant();
		test_io_mode();
		finish_test();
	end
endmodule
`default_nettype wire
